//--- hw/hpe_engine.sv
// Purpose: haptic playback engine, register file, triggers and sequencer
// Assumes: register port already decoded from the serial bus
// Notes: trigger pin is sampled as synchronous to clk
`timescale 1ns/10ps
`include "hpe_map.svh"
module hpe_engine #(
    parameter int TICK_CYC   = `HPE_STEP_CYC,
    parameter int WAVE_TICKS = 8,
    parameter int BRK_TICKS  = 2
) (
    // system
    input  wire logic       clk,
    input  wire logic       rst,
    // register port
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,
    // trigger pin
    input  wire logic       trigger_interrupt_pin,
    // drive result
    output logic [7:0]      drive_level,
    output logic            drive_neg,
    output logic            drive_brake,
    output logic            drive_flip,
    output logic            overdrive_on,
    output logic            playing
);
    hpe_pkg::hpe_eng_t q, d;
    logic [1:0]        mode;
    logic [1:0]        trig_fn;
    logic              idle;
    logic              go_wr;
    logic              pin_rise;
    logic              pin_fall;
    logic              start_req;
    logic              stop_req;
    logic              mode_chg;
    logic [7:0]        cur;
    logic              do_next;
    logic              do_end;
    logic              do_finish;
    logic              drv_en;
    logic [7:0]        drv_val;
    logic [7:0]        wav_amp;
    logic              wav_done;

    // addresses that hold one of the eight sequence slots
    function automatic logic is_slot(input logic [7:0] a);
        is_slot = (a >= `HPE_A_SLOT1) && (a <= `HPE_A_SLOT8);
    endfunction

    // slot number from a slot address
    function automatic logic [2:0] slot_ix(input logic [7:0] a);
        logic [7:0] o;
        o = a - `HPE_A_SLOT1;
        slot_ix = o[2:0];
    endfunction

    // repeat count of one slot, two bits each, packed four to a register
    function automatic logic [1:0] slot_loops(input logic [2:0] i, input logic [7:0] la,
                                              input logic [7:0] lb);
        logic [7:0] r;
        r = i[2] ? lb : la;
        slot_loops = r[2 * i[1:0] +: 2];
    endfunction

    // register read mux; unknown addresses read zero
    function automatic logic [7:0] rd_mux(input hpe_pkg::hpe_eng_t s, input logic [7:0] a);
        rd_mux = 8'h00;
        case (a)
            `HPE_A_CTRL1:   rd_mux = s.ctrl1;
            `HPE_A_CTRL2:   rd_mux = s.ctrl2;
            `HPE_A_GO:      rd_mux = {7'h00, s.go};
            `HPE_A_RTP:     rd_mux = s.realtime_playback;
            `HPE_A_LOOPA:   rd_mux = s.loopa;
            `HPE_A_LOOPB:   rd_mux = s.loopb;
            `HPE_A_MAIN:    rd_mux = {5'h00, s.mainl};
            `HPE_A_RATED:   rd_mux = s.rated;
            `HPE_A_ODCLAMP: rd_mux = s.odc;
            `HPE_A_RCLAMP:  rd_mux = s.rcl;
            `HPE_A_ODTIME:  rd_mux = {6'h00, s.odt};
            default:
            begin
                if (is_slot(a))
                    rd_mux = s.slot[slot_ix(a)];
            end
        endcase
    endfunction

    // trigger decode from the launch bit and the pin
    always_comb
    begin
        mode = q.ctrl1[`HPE_F_MODE];
        trig_fn = q.ctrl1[`HPE_F_TRIG];
        idle = (q.fsm == hpe_pkg::S_IDLE);
        go_wr = reg_wr && (reg_addr == `HPE_A_GO);
        pin_rise = trigger_interrupt_pin && !q.pin;
        pin_fall = !trigger_interrupt_pin && q.pin;
        // a pulse toggles run state; a level runs while high
        start_req = (go_wr && reg_wdata[0] && trig_fn != `HPE_TRIG_LEVEL)
                    || (trig_fn == `HPE_TRIG_PULSE && pin_rise && idle)
                    || (trig_fn == `HPE_TRIG_LEVEL && pin_rise);
        stop_req = (go_wr && !reg_wdata[0] && trig_fn != `HPE_TRIG_LEVEL)
                   || (trig_fn == `HPE_TRIG_PULSE && pin_rise && !idle)
                   || (trig_fn == `HPE_TRIG_LEVEL && pin_fall);
        mode_chg = reg_wr && (reg_addr == `HPE_A_CTRL1)
                   && (reg_wdata[`HPE_F_MODE] != mode);
        cur = q.slot[q.idx];
    end

    // drive value; open loop realtime input is offset binary around mid-scale
    always_comb
    begin
        drv_en = 1'b0;
        drv_val = 8'h00;
        case (q.fsm)
            hpe_pkg::S_RTP:
            begin
                drv_en = 1'b1;
                drv_val = q.ctrl2[`HPE_B_OPEN] ? (q.realtime_playback ^ `HPE_MID) : q.realtime_playback;
            end
            hpe_pkg::S_PLAY:
            begin
                drv_en = 1'b1;
                drv_val = wav_amp;
            end
            hpe_pkg::S_BRAKE:
            begin
                drv_en = 1'b1;
                drv_val = `HPE_BRAKE_VAL;
            end
            default:
            begin
                drv_en = 1'b0;
                drv_val = 8'h00;
            end
        endcase
    end

    // registers, divider and playback state machine
    always_comb
    begin
        d = q;
        d.pin = trigger_interrupt_pin;
        d.wgo = 1'b0;
        do_next = 1'b0;
        do_end = 1'b0;
        do_finish = 1'b0;
        // 10 ms step enable
        d.tick = 1'b0;
        if (q.div == 17'(TICK_CYC - 1))
        begin
            d.div = 17'h00000;
            d.tick = 1'b1;
        end
        else
            d.div = q.div + 17'h00001;
        // register writes; a launch bit write only moves the state machine
        if (reg_wr)
        begin
            case (reg_addr)
                `HPE_A_CTRL1:   d.ctrl1 = reg_wdata;
                `HPE_A_CTRL2:   d.ctrl2 = reg_wdata;
                `HPE_A_RTP:     d.realtime_playback = reg_wdata;
                `HPE_A_LOOPA:   d.loopa = reg_wdata;
                `HPE_A_LOOPB:   d.loopb = reg_wdata;
                `HPE_A_MAIN:    d.mainl = reg_wdata[`HPE_F_MAIN];
                `HPE_A_RATED:   d.rated = reg_wdata;
                `HPE_A_ODCLAMP: d.odc = reg_wdata;
                `HPE_A_RCLAMP:  d.rcl = reg_wdata;
                `HPE_A_ODTIME:  d.odt = reg_wdata[`HPE_F_ODTIME];
                default:
                begin
                    if (is_slot(reg_addr))
                        d.slot[slot_ix(reg_addr)] = reg_wdata;
                end
            endcase
        end
        if (reg_rd)
            d.rdata = rd_mux(q, reg_addr);
        // main sequence
        case (q.fsm)
            hpe_pkg::S_IDLE:
            begin
                if (start_req && mode == `HPE_MODE_RTP)
                    d.fsm = hpe_pkg::S_RTP;
                else if (start_req && mode == `HPE_MODE_SEQ)
                begin
                    d.fsm = hpe_pkg::S_SLOT;
                    d.idx = 3'h0;
                    d.sloop = 2'h0;
                    d.mloop = 3'h0;
                end
            end
            hpe_pkg::S_RTP:
            begin
                if (mode_chg)
                    do_finish = 1'b1;
            end
            hpe_pkg::S_SLOT:
            begin
                if (cur == 8'h00)
                    do_end = 1'b1;
                else if (cur[`HPE_B_WAIT])
                begin
                    d.wcnt = cur[6:0];
                    d.fsm = hpe_pkg::S_WAIT;
                end
                else
                begin
                    d.wgo = 1'b1;
                    d.fsm = hpe_pkg::S_PLAY;
                end
            end
            hpe_pkg::S_PLAY:
            begin
                if (wav_done)
                    do_next = 1'b1;
            end
            hpe_pkg::S_WAIT:
            begin
                // the step only ends once every 10 ms unit has passed
                if (q.wcnt == 7'h00)
                    do_next = 1'b1;
                else if (q.tick)
                    d.wcnt = q.wcnt - 7'h01;
            end
            hpe_pkg::S_BRAKE:
            begin
                if (q.tick && q.wcnt == 7'h00)
                    d.fsm = hpe_pkg::S_IDLE;
                else if (q.tick)
                    d.wcnt = q.wcnt - 7'h01;
            end
            default:
                d.fsm = hpe_pkg::S_IDLE;
        endcase
        // next slot or next repeat of this slot
        if (do_next)
        begin
            if (q.sloop < slot_loops(q.idx, q.loopa, q.loopb))
            begin
                d.sloop = q.sloop + 2'h1;
                d.fsm = hpe_pkg::S_SLOT;
            end
            else if (q.idx == 3'h7)
                do_end = 1'b1;
            else
            begin
                d.sloop = 2'h0;
                d.idx = q.idx + 3'h1;
                d.fsm = hpe_pkg::S_SLOT;
            end
        end
        // end of one pass over the slots
        if (do_end)
        begin
            if (q.mainl == `HPE_MAIN_INF || q.mloop < q.mainl)
            begin
                if (q.mainl != `HPE_MAIN_INF)
                    d.mloop = q.mloop + 3'h1;
                d.idx = 3'h0;
                d.sloop = 2'h0;
                d.fsm = hpe_pkg::S_SLOT;
            end
            else
                do_finish = 1'b1;
        end
        // a stop wins over whatever the sequence was doing
        if (stop_req && !idle && q.fsm != hpe_pkg::S_BRAKE)
            do_finish = 1'b1;
        if (do_finish)
        begin
            d.wgo = 1'b0;
            if (q.ctrl2[`HPE_B_BSTBY])
            begin
                d.fsm = hpe_pkg::S_BRAKE;
                d.wcnt = 7'(BRK_TICKS - 1);
            end
            else
                d.fsm = hpe_pkg::S_IDLE;
        end
        // a timed phase starts on a fresh 10 ms step, so its first unit is whole
        if (d.fsm != q.fsm
            && (d.fsm == hpe_pkg::S_WAIT || d.fsm == hpe_pkg::S_PLAY || d.fsm == hpe_pkg::S_BRAKE))
        begin
            d.div = 17'h00000;
            d.tick = 1'b0;
        end
        d.go = (d.fsm != hpe_pkg::S_IDLE);
    end

    // state register with documented reset values
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q <= '0;
            q.ctrl1 <= `HPE_R_CTRL1;
            q.ctrl2 <= `HPE_R_CTRL2;
            q.realtime_playback <= `HPE_R_RTP;
            q.slot[0] <= `HPE_R_SLOT1;
            q.rated <= `HPE_R_RATED;
            q.odc <= `HPE_R_ODCLAMP;
            q.rcl <= `HPE_R_RCLAMP;
        end
        else
            q <= d;
    end

    // library effect player; a stop cuts it short
    hpe_wave #(
        .WAVE_TICKS (WAVE_TICKS)
    ) u_wave (
        .clk  (clk),
        .rst  (rst),
        .tick (q.tick),
        .go   (q.wgo),
        .halt (q.fsm != hpe_pkg::S_PLAY),
        .id   (cur[6:0]),
        .amp  (wav_amp),
        .done (wav_done)
    );

    // output stage, registered inside
    hpe_drive u_drive (
        .clk         (clk),
        .rst         (rst),
        .en          (drv_en),
        .tick        (q.tick),
        .open_loop   (q.ctrl2[`HPE_B_OPEN]),
        .auto_brk_ol (q.ctrl2[`HPE_B_ABOL]),
        .lra         (q.ctrl2[`HPE_B_LRA]),
        .value       (drv_val),
        .rated       (q.rated),
        .overdrive_limit_level    (q.odc),
        .rated_clamp (q.rcl),
        .od_time     (q.odt),
        .level       (drive_level),
        .neg         (drive_neg),
        .brake       (drive_brake),
        .flip        (drive_flip),
        .od_on       (overdrive_on)
    );

    assign reg_rdata = q.rdata;
    assign playing = q.go;

    rtp_start_a: assert property (
        @(posedge clk) disable iff (rst)
        (idle && start_req && mode == `HPE_MODE_RTP) |=> (q.fsm == hpe_pkg::S_RTP))
        else $error("realtime playback did not start");
    level_ignore_a: assert property (
        @(posedge clk) disable iff (rst)
        (idle && trig_fn == `HPE_TRIG_LEVEL && go_wr && !pin_rise) |=> idle)
        else $error("launch bit started level-trigger playback");
    stop_ends_a: assert property (
        @(posedge clk) disable iff (rst)
        (stop_req && (q.fsm == hpe_pkg::S_RTP || q.fsm == hpe_pkg::S_PLAY))
        |=> (q.fsm == hpe_pkg::S_IDLE || q.fsm == hpe_pkg::S_BRAKE))
        else $error("stop request ignored");
    mode_stop_a: assert property (
        @(posedge clk) disable iff (rst)
        (q.fsm == hpe_pkg::S_RTP && mode_chg) |=> (q.fsm != hpe_pkg::S_RTP))
        else $error("mode change did not stop realtime playback");
    zero_slot_a: assert property (
        @(posedge clk) disable iff (rst)
        (q.fsm == hpe_pkg::S_SLOT && cur == 8'h00 && q.mainl == 3'h0)
        |=> (q.fsm == hpe_pkg::S_IDLE || q.fsm == hpe_pkg::S_BRAKE))
        else $error("sequence ran past an empty slot");
    wait_hold_a: assert property (
        @(posedge clk) disable iff (rst)
        (q.fsm == hpe_pkg::S_WAIT && q.wcnt != 7'h00 && !stop_req) |=> (q.fsm == hpe_pkg::S_WAIT))
        else $error("wait step left early");
endmodule

//--- hw/hpe_map.svh
// Purpose: offsets, fields, reset values and timing of the playback engine
// Assumes: 8-bit register port, 10 MHz clock
// Notes: ranges are given as macros so they can index a vector directly
`ifndef HPE_MAP_SVH
`define HPE_MAP_SVH
`define HPE_CLK_HZ      10000000
`define HPE_STEP_MS     10
`define HPE_STEP_CYC    ((`HPE_CLK_HZ / 1000) * `HPE_STEP_MS)
`define HPE_A_CTRL1     8'h07
`define HPE_A_CTRL2     8'h08
`define HPE_A_GO        8'h0c
`define HPE_A_RTP       8'h0e
`define HPE_A_SLOT1     8'h0f
`define HPE_A_SLOT8     8'h16
`define HPE_A_LOOPA     8'h17
`define HPE_A_LOOPB     8'h18
`define HPE_A_MAIN      8'h19
`define HPE_A_RATED     8'h1f
`define HPE_A_ODCLAMP   8'h20
`define HPE_A_RCLAMP    8'h24
`define HPE_A_ODTIME    8'h25
`define HPE_R_CTRL1     8'h54
`define HPE_R_CTRL2     8'h88
`define HPE_R_RTP       8'h7f
`define HPE_R_SLOT1     8'h01
`define HPE_R_RATED     8'h3f
`define HPE_R_ODCLAMP   8'h89
`define HPE_R_RCLAMP    8'h64
`define HPE_F_MODE      1:0
`define HPE_F_TRIG      3:2
`define HPE_F_MAIN      2:0
`define HPE_F_ODTIME    1:0
`define HPE_B_LRA       7
`define HPE_B_OPEN      6
`define HPE_B_ABOL      4
`define HPE_B_BSTBY     3
`define HPE_B_WAIT      7
`define HPE_MODE_RTP    2'h0
`define HPE_MODE_SEQ    2'h1
`define HPE_TRIG_PULSE  2'h0
`define HPE_TRIG_LEVEL  2'h1
`define HPE_MAIN_INF    3'h7
`define HPE_MID         8'h80
`define HPE_BRAKE_VAL   8'h81
`endif

//--- hw/hpe_pkg.sv
// Purpose: state types of the playback engine
// Assumes: numbers live in hpe_map.svh
// Notes: every module keeps all of its state in one packed struct
package hpe_pkg;
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_RTP   = 3'b001,
        S_SLOT  = 3'b010,
        S_PLAY  = 3'b011,
        S_WAIT  = 3'b100,
        S_BRAKE = 3'b101
    } hpe_state_t;
    typedef struct packed {
        hpe_state_t      fsm;
        logic [7:0]      ctrl1;
        logic [7:0]      ctrl2;
        logic [7:0]      realtime_playback;
        logic [7:0][7:0] slot;
        logic [7:0]      loopa;
        logic [7:0]      loopb;
        logic [2:0]      mainl;
        logic [7:0]      rated;
        logic [7:0]      odc;
        logic [7:0]      rcl;
        logic [1:0]      odt;
        logic            go;
        logic [2:0]      idx;
        logic [1:0]      sloop;
        logic [2:0]      mloop;
        logic [6:0]      wcnt;
        logic [16:0]     div;
        logic            tick;
        logic            pin;
        logic            wgo;
        logic [7:0]      rdata;
    } hpe_eng_t;
    typedef struct packed {
        logic [7:0] level;
        logic       neg;
        logic       brake;
        logic       flip;
        logic       od_on;
        logic       acc;
        logic       live;
        logic [2:0] odcnt;
    } hpe_drv_t;
    typedef struct packed {
        logic       busy;
        logic       done;
        logic [7:0] cnt;
        logic [6:0] id;
        logic [7:0] amp;
    } hpe_wav_t;
endpackage

//--- hw/hpe_wave.sv
// Purpose: plays one library effect as a stream of signed drive values
// Assumes: tick is a one-cycle 10 ms enable
// Notes: effect content is a stand-in, a forward kick then a brake tail
`timescale 1ns/10ps
module hpe_wave #(
    parameter int WAVE_TICKS = 8
) (
    // system
    input  wire logic       clk,
    input  wire logic       rst,
    // control
    input  wire logic       tick,
    input  wire logic       go,
    input  wire logic       halt,
    input  wire logic [6:0] id,
    // result
    output logic [7:0]      amp,
    output logic            done
);
    hpe_pkg::hpe_wav_t q, d;
    logic [7:0]        nc;

    // one effect: drive at the identifier's strength, reverse in the last step
    always_comb
    begin
        d = q;
        d.done = 1'b0;
        nc = q.cnt + 8'h01;
        if (halt)
        begin
            d.busy = 1'b0;
            d.amp = 8'h00;
        end
        else if (go)
        begin
            d.busy = 1'b1;
            d.cnt = 8'h00;
            d.id = id;
            d.amp = {1'b0, id};
        end
        else if (q.busy && tick)
        begin
            d.cnt = nc;
            if (nc == 8'(WAVE_TICKS))
            begin
                d.busy = 1'b0;
                d.done = 1'b1;
                d.amp = 8'h00;
            end
            else if (nc == 8'(WAVE_TICKS - 1))
                d.amp = 8'(-{1'b0, q.id});
        end
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

    assign amp = q.amp;
    assign done = q.done;
endmodule

//--- hw/hpe_drive.sv
// Purpose: turns a signed drive value into level, direction and brake
// Assumes: tick is a one-cycle 10 ms enable
// Notes: no back-EMF here, overdrive is a timed kick at each closed loop phase start, none in open loop
`timescale 1ns/10ps
module hpe_drive (
    // system
    input  wire logic       clk,
    input  wire logic       rst,
    // control
    input  wire logic       en,
    input  wire logic       tick,
    input  wire logic       open_loop,
    input  wire logic       auto_brk_ol,
    input  wire logic       lra,
    input  wire logic [7:0] value,
    input  wire logic [7:0] rated,
    input  wire logic [7:0] overdrive_limit_level,
    input  wire logic [7:0] rated_clamp,
    input  wire logic [1:0] od_time,
    // drive result
    output logic [7:0]      level,
    output logic            neg,
    output logic            brake,
    output logic            flip,
    output logic            od_on
);
    hpe_pkg::hpe_drv_t q, d;
    logic [7:0]        mag;
    logic [7:0]        steady;
    logic [7:0]        hold;
    logic              accel;
    logic              restart;
    logic              kick;

    // magnitude times reference over full scale; m is at most 128
    function automatic logic [7:0] scale(input logic [7:0] m, input logic [7:0] r);
        logic [15:0] p;
        p = 16'(m) * 16'(r);
        scale = p[14:7];
    endfunction

    // sign is direction, magnitude is strength
    always_comb
    begin
        d = q;
        mag = value[7] ? 8'(-value) : value;
        accel = !value[7] && (value != 8'h00);
        restart = (accel != q.acc) || !q.live;
        kick = restart || (q.odcnt <= {1'b0, od_time});
        // the lower clamp itself never rises above the overdrive clamp
        hold = (rated_clamp > overdrive_limit_level) ? overdrive_limit_level : rated_clamp;
        steady = scale(mag, rated);
        if (steady > hold)
            steady = hold;
        if (!en)
            d = '0;
        else if (open_loop)
        begin
            d.level = scale(mag, overdrive_limit_level);
            d.neg = value[7];
            d.brake = auto_brk_ol && value[7];
            d.flip = lra && value[7] && !d.brake;
            d.od_on = 1'b0;
            d.odcnt = 3'h0;
            d.live = 1'b0;
        end
        else
        begin
            d.live = 1'b1;
            d.acc = accel;
            d.neg = !accel;
            d.brake = !accel;
            d.flip = 1'b0;
            d.od_on = kick;
            if (restart)
                d.odcnt = 3'h0;
            else if (tick && kick)
                d.odcnt = q.odcnt + 3'h1;
            // after the kick, hold the rated level (capped at the lower clamp) while accelerating, the lower clamp while braking
            if (accel)
                d.level = kick ? overdrive_limit_level : steady;
            else
                d.level = kick ? overdrive_limit_level : hold;
        end
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

    assign level = q.level;
    assign neg = q.neg;
    assign brake = q.brake;
    assign flip = q.flip;
    assign od_on = q.od_on;

    open_scale_a: assert property (
        @(posedge clk) disable iff (rst)
        (en && open_loop && value == 8'h7f) |=> (level == scale(8'h7f, $past(overdrive_limit_level))))
        else $error("open loop level not scaled to clamp");
    closed_brake_a: assert property (
        @(posedge clk) disable iff (rst)
        (en && !open_loop && !(value != 8'h00 && !value[7])) |=> (brake && neg))
        else $error("closed loop zero or negative did not brake");
    od_cap_a: assert property (
        @(posedge clk) disable iff (rst)
        (en && !open_loop && $stable(overdrive_limit_level)) |=> (level <= $past(overdrive_limit_level)))
        else $error("closed loop level above clamp");
endmodule

//--- bench/hpe_host.sv
// Purpose: host model, register port writes and reads plus the trigger pin
// Assumes: strobes are one-cycle pulses taken at the rising edge
// Notes: signals change at the falling edge, away from sampling
`timescale 1ns/10ps
module hpe_host (
    // system
    input  wire logic       clk,
    // register port
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata,
    // trigger pin
    output logic            pin
);
    // idle bus, pin low until a trigger is wanted
    initial
    begin
        {reg_wr, reg_rd, pin, reg_addr, reg_wdata} = '0;
    end
    // a gap cycle between strobes keeps each one a clean pulse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    // data is taken one cycle after the strobe drops, a cycle and a half after the read edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    // level on the pin starts and ends playback in level mode
    task automatic trig(input logic v);
        @(negedge clk);
        pin = v;
    endtask
endmodule

//--- bench/test_hpe_engine.sv
// Purpose: self-checking bench of the playback engine
// Assumes: short tick and effect lengths set through parameters
// Notes: drive values are looked at a few cycles after each register write
`timescale 1ns/10ps
`include "hpe_map.svh"
module test_hpe_engine;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr, reg_rd, pin, drive_neg, drive_brake, drive_flip, overdrive_on, playing;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, drive_level, d;
    int n_errors = 0;
    int comparisons = 0;
    hpe_host host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin(pin));
    hpe_engine #(.TICK_CYC(10), .WAVE_TICKS(4), .BRK_TICKS(1)) uut (.clk(clk), .rst(rst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .trigger_interrupt_pin(pin), .drive_level(drive_level),
        .drive_neg(drive_neg), .drive_brake(drive_brake), .drive_flip(drive_flip),
        .overdrive_on(overdrive_on), .playing(playing));
    // 100 ns period
    initial
    begin
        forever #50 clk = ~clk;
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    // bounded wait on playing; running out ends the run
    task automatic wt(input logic v, input string s);
        for (int i = 0; i < 60 && playing !== v; i++)
            @(negedge clk);
        chk(s, {7'h0, v}, {7'h0, playing});
        if (playing !== v)
            complete_run();
    endtask
    task automatic t_reset();
        host.rd(`HPE_A_CTRL1, d);
        chk("ctrl1", `HPE_R_CTRL1, d);
        host.rd(`HPE_A_SLOT1, d);
        chk("slot1", `HPE_R_SLOT1, d);
        host.rd(8'h30, d);
        chk("unmapped", 8'h00, d);
        $display("reset test done");
    endtask
    task automatic t_rtp();
        host.wr(`HPE_A_CTRL1, 8'h00);
        host.wr(`HPE_A_CTRL2, 8'h40);
        host.wr(`HPE_A_RTP, `HPE_MID);
        host.wr(`HPE_A_GO, 8'h01);
        wt(1'b1, "rtp start");
        repeat (3) @(negedge clk);
        chk("mid level", 8'h00, drive_level);
        host.wr(`HPE_A_RTP, 8'h00);
        repeat (3) @(negedge clk);
        chk("open neg", 8'h01, {7'h0, drive_neg});
        chk("full scale", `HPE_R_ODCLAMP, drive_level);
        host.wr(`HPE_A_CTRL2, 8'hc0);
        repeat (3) @(negedge clk);
        chk("lra flip", 8'h01, {7'h0, drive_flip});
        host.wr(`HPE_A_CTRL2, 8'hd0);
        repeat (3) @(negedge clk);
        chk("auto brake", 8'h01, {7'h0, drive_brake});
        chk("no flip", 8'h00, {7'h0, drive_flip});
        host.wr(`HPE_A_CTRL2, 8'h00);
        repeat (3) @(negedge clk);
        chk("closed brake", 8'h01, {7'h0, drive_brake});
        repeat (20) @(negedge clk);
        chk("brake clamp", `HPE_R_RCLAMP, drive_level);
        chk("kick over", 8'h00, {7'h0, overdrive_on});
        host.wr(`HPE_A_CTRL1, 8'h01);
        wt(1'b0, "mode change stop");
        $display("realtime test done");
    endtask
    task automatic t_level();
        host.wr(`HPE_A_CTRL1, 8'h04);
        host.wr(`HPE_A_GO, 8'h01);
        repeat (4) @(negedge clk);
        chk("go ignored", 8'h00, {7'h0, playing});
        host.trig(1'b1);
        wt(1'b1, "pin start");
        host.trig(1'b0);
        wt(1'b0, "pin stop");
        $display("level test done");
    endtask
    task automatic t_seq();
        host.wr(`HPE_A_CTRL1, 8'h01);
        host.wr(`HPE_A_SLOT1, 8'h81);
        host.wr(`HPE_A_LOOPA, 8'h01);
        host.wr(`HPE_A_GO, 8'h01);
        wt(1'b1, "seq start");
        repeat (5) @(negedge clk);
        chk("in wait", 8'h01, {7'h0, playing});
        repeat (14) @(negedge clk);
        chk("slot repeat", 8'h01, {7'h0, playing});
        wt(1'b0, "seq end");
        host.rd(`HPE_A_GO, d);
        chk("go clear", 8'h00, d);
        host.wr(`HPE_A_SLOT1, 8'hff);
        host.wr(`HPE_A_CTRL2, 8'h08);
        host.trig(1'b1);
        host.trig(1'b0);
        wt(1'b1, "pulse start");
        host.wr(`HPE_A_GO, 8'h00);
        repeat (2) @(negedge clk);
        chk("stop brake", 8'h01, {7'h0, drive_brake});
        chk("brake plays", 8'h01, {7'h0, playing});
        wt(1'b0, "brake end");
        $display("sequencer test done");
    endtask
    // reset 16 cycles, then the scenarios in turn
    initial
    begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_rtp();
        t_level();
        t_seq();
        complete_run();
    end
endmodule
